// file: hw/mrc_multirate.sv
// Purpose: multirate datapath with clearable enable generator
// Assumes: ce_clr and data come from logic on sys_clk
// Notes:   slow rate is RATIO clocks; serial stream buffered in fifo
`timescale 1ns/1ps
`default_nettype none
module mrc_multirate (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic                  ce,
    input  wire logic                  ce_clr,
    input  wire logic [mrc_pkg::DW-1:0] fast_in,
    input  wire logic [mrc_pkg::DW-1:0] slow_in,
    input  wire mrc_pkg::mrc_frame_t    par_in,
    input  wire logic [mrc_pkg::AW-1:0] store_addr,
    output logic                        ce_slow,
    output mrc_pkg::mrc_taps_t          taps,
    output mrc_pkg::mrc_frame_t         demux_out,
    output mrc_pkg::mrc_frame_t         par_out,
    output logic [mrc_pkg::DW-1:0]      ser_q_data,
    output logic                        ser_q_valid,
    input  wire logic                   ser_q_ready
);
    import mrc_pkg::*;

    // index of a frame's word by phase
    function automatic logic [DW-1:0] pick(input mrc_frame_t f, input logic [CW-1:0] i);
        case (i)
            2'h0:    pick = f.ch0;
            2'h1:    pick = f.ch1;
            2'h2:    pick = f.ch2;
            default: pick = f.ch3;
        endcase
    endfunction

    // ---------------- enable generator
    logic [CW-1:0] phase_r, phase_nxt;
    logic          ce_slow_nxt, en_slow;

    // counter held cleared under clear, restarts on release
    always_comb begin
        if (ce_clr) begin
            phase_nxt = PHASE_RST;                    // see RQ1
        end else begin
            phase_nxt = phase_r + 2'h1;               // see RQ16
        end
        ce_slow_nxt = !ce_clr && phase_nxt == PHASE_END; // see RQ2
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= PHASE_RST;
            ce_slow <= 1'b0;
        end else if (ce) begin
            phase_r <= phase_nxt;
            ce_slow <= ce_slow_nxt;
        end
    end
    assign en_slow = ce_slow;

    // ---------------- samplers, mux, demux, converters
    mrc_taps_t       taps_nxt;
    mrc_frame_t      demux_nxt, par_nxt, shadow_r, shadow_nxt, pin_r, pin_nxt;
    mrc_mux_state_t  mst_r, mst_nxt;
    logic [CW-1:0]   mux_i_r, mux_i_nxt, ser_i_r, ser_i_nxt, dem_i_r, dem_i_nxt;
    logic [DW-1:0]   store_r [STORE_DEPTH];
    logic [DW-1:0]   store_nxt [STORE_DEPTH];
    logic [DW-1:0]   fq_data;
    logic            fq_valid, fq_ready, first_armed_r, first_armed_nxt;
    logic            zhold_r, zhold_nxt;

    always_comb begin
        taps_nxt        = taps;
        demux_nxt       = demux_out;
        par_nxt         = par_out;
        shadow_nxt      = shadow_r;
        pin_nxt         = pin_r;
        mst_nxt         = mst_r;
        mux_i_nxt       = mux_i_r;
        ser_i_nxt       = ser_i_r;
        dem_i_nxt       = dem_i_r;
        first_armed_nxt = first_armed_r;
        fq_valid        = 1'b0;
        fq_data         = taps.ser_out;
        for (int k = 0; k < STORE_DEPTH; k++)
            store_nxt[k] = store_r[k];

        taps_nxt.up_copy = slow_in;                    // see RQ5
        if (en_slow)
            taps_nxt.slow_last = fast_in;              // see RQ3
        // first-value sampler free-runs on its own count, blind to clear
        first_armed_nxt = !first_armed_r;
        if (first_armed_r)
            taps_nxt.slow_first = fast_in;             // see RQ4
        // zero insert: a clear freezes the last output until the next enable
        zhold_nxt = ce_clr || (zhold_r && !en_slow);   // see RQ6
        if (en_slow)
            taps_nxt.up_zero = slow_in;                // see RQ6
        else if (!ce_clr && !zhold_r)
            taps_nxt.up_zero = DATA_RST;               // see RQ6

        // mux: step on from own index, zero after last, realign on enable
        case (mst_r)
            MRC_ALIGNED: begin
                taps_nxt.mux_out = pick(par_in, mux_i_r);
                mux_i_nxt        = mux_i_r + 2'h1;
                if (ce_clr)
                    mst_nxt = MRC_DRAIN;
            end
            MRC_DRAIN: begin
                if (en_slow) begin
                    mst_nxt          = MRC_ALIGNED;    // see RQ7
                    mux_i_nxt        = 2'h1;
                    taps_nxt.mux_out = par_in.ch0;
                end else if (mux_i_r != PHASE_RST) begin
                    taps_nxt.mux_out = pick(par_in, mux_i_r);
                    mux_i_nxt        = mux_i_r + 2'h1;
                end else begin
                    taps_nxt.mux_out = DATA_RST;       // see RQ7
                end
            end
            default: mst_nxt = MRC_ALIGNED;
        endcase

        // demux: collect fast words, publish a whole frame on enable
        if (en_slow) begin
            demux_nxt = shadow_r;                      // see RQ8
            dem_i_nxt = PHASE_RST;
        end else if (!ce_clr && dem_i_r != PHASE_END) begin
            dem_i_nxt = dem_i_r + 2'h1;
        end
        case (dem_i_r)
            2'h0:    shadow_nxt.ch0 = fast_in;
            2'h1:    shadow_nxt.ch1 = fast_in;
            2'h2:    shadow_nxt.ch2 = fast_in;
            default: shadow_nxt.ch3 = fast_in;
        endcase

        // serializer: load on enable, else finish words then hold last
        if (en_slow) begin
            pin_nxt          = par_in;                 // see RQ9
            taps_nxt.ser_out = par_in.ch0;
            ser_i_nxt        = 2'h1;
            fq_valid         = 1'b1;
        end else if (ser_i_r != PHASE_RST) begin
            taps_nxt.ser_out = pick(pin_r, ser_i_r);   // see RQ9
            ser_i_nxt        = ser_i_r + 2'h1;
            fq_valid         = 1'b1;
        end
        fq_data = taps_nxt.ser_out;

        // deserializer: frozen under clear, captures at frame end, shows on enable
        if (!ce_clr) begin
            if (dem_i_r == PHASE_END)
                shadow_nxt.ch3 = fast_in;              // see RQ10
            if (en_slow)
                par_nxt = shadow_r;                    // see RQ10
        end else begin
            par_nxt = par_out;                         // see RQ10
        end

        // shift store: contents kept while clear, then shift again
        if (!ce_clr) begin
            for (int k = STORE_DEPTH-1; k > 0; k--)
                store_nxt[k] = store_r[k-1];           // see RQ11
            store_nxt[0] = fast_in;
        end
        taps_nxt.store_out = store_r[store_addr];
    end

    // serial stream buffered; a full fifo holds the serializer word, yet a slow enable drops unsent words or, if stalled, the new frame
    logic stall;
    assign stall = fq_valid && !fq_ready;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            taps          <= '0;
            demux_out     <= '0;
            par_out       <= '0;
            shadow_r      <= '0;
            pin_r         <= '0;
            mst_r         <= MRC_ALIGNED;
            mux_i_r       <= PHASE_RST;
            ser_i_r       <= PHASE_RST;
            dem_i_r       <= PHASE_RST;
            first_armed_r <= 1'b0;
            zhold_r       <= 1'b0;
            for (int k = 0; k < STORE_DEPTH; k++)
                store_r[k] <= DATA_RST;
        end else if (ce) begin
            taps          <= taps_nxt;
            demux_out     <= demux_nxt;
            par_out       <= par_nxt;
            shadow_r      <= shadow_nxt;
            mst_r         <= mst_nxt;
            mux_i_r       <= mux_i_nxt;
            dem_i_r       <= dem_i_nxt;
            first_armed_r <= first_armed_nxt;
            if (!stall) begin
                pin_r   <= pin_nxt;
                ser_i_r <= ser_i_nxt;
            end
            zhold_r       <= zhold_nxt;
            for (int k = 0; k < STORE_DEPTH; k++)
                store_r[k] <= store_nxt[k];
        end
    end

    mrc_fifo #(.W(DW), .D(FIFO_DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .ce        (ce),
        .in_data   (fq_data),
        .in_valid  (fq_valid),
        .in_ready  (fq_ready),
        .out_data  (ser_q_data),
        .out_valid (ser_q_valid),
        .out_ready (ser_q_ready)
    );
endmodule // mrc_multirate
`default_nettype wire

// file: hw/mrc_pkg.sv
// Purpose: constants and types for the multirate enable-clear block
// Assumes: one clock, per-rate enables derived from one generator
// Notes:   rate ratio and widths are fixed
//
// Overview of operation
// (RQ1) one clock, enable generator reset by clear
// (RQ2) clear release re-phases every derived enable
// (RQ3) last-value down sampler holds until enable
// (RQ4) first-value down sampler never re-synchronises
// (RQ5) copying up sampler is a plain wire; here it is registered, one clock late
// (RQ6) zero-insert up sampler holds, resyncs one cycle
// (RQ7) mux finishes channels, drives zero, realigns
// (RQ8) demux holds outputs until next enable
// (RQ9) serializer finishes words, holds last, restarts
// (RQ10) deserializer freezes on clear, captures frame end
// (RQ11) shift store keeps contents, then shifts on
// (RQ12) partner resets polyphase filter after release
// (RQ13) partner tolerates N invalid cycles after release
// (RQ14) partner may use counter-based replacements
// (RQ15) partner resets accumulate counters with clear
// (RQ16) enable pulses once per N clocks from counter
package mrc_pkg;
    localparam int DW          = 16;   // sample width
    localparam int RATIO       = 4;    // slow rate period in clocks
    localparam int CW          = 2;    // phase counter width
    localparam int STORE_DEPTH = 8;    // shift store depth
    localparam int AW          = 3;    // shift store index width
    localparam int FIFO_DEPTH  = 16;   // output fifo depth
    localparam logic [CW-1:0] PHASE_RST = 2'h0;
    localparam logic [CW-1:0] PHASE_END = 2'h3;
    localparam logic [DW-1:0] DATA_RST  = 16'h0000;

    typedef enum {MRC_ALIGNED, MRC_DRAIN} mrc_mux_state_t;

    typedef struct packed {
        logic [DW-1:0] slow_last;
        logic [DW-1:0] slow_first;
        logic [DW-1:0] up_copy;
        logic [DW-1:0] up_zero;
        logic [DW-1:0] mux_out;
        logic [DW-1:0] ser_out;
        logic [DW-1:0] store_out;
    } mrc_taps_t;

    typedef struct packed {
        logic [DW-1:0] ch3;
        logic [DW-1:0] ch2;
        logic [DW-1:0] ch1;
        logic [DW-1:0] ch0;
    } mrc_frame_t;
endpackage

// file: hw/mrc_fifo.sv
// Purpose: flip-flop fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   registered outputs; full/empty exact
`timescale 1ns/1ps
`default_nettype none
module mrc_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int PW = $clog2(D);
    logic [W-1:0]  mem_r [D];
    logic [PW:0]   wp_r, wp_nxt, rp_r, rp_nxt;
    logic          push, pop;

    // pointers carry a wrap bit so full and empty are distinct
    always_comb begin
        push   = in_valid && in_ready;
        pop    = out_valid && out_ready;
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wp_r      <= '0;
            rp_r      <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (ce) begin
            wp_r      <= wp_nxt;
            rp_r      <= rp_nxt;
            in_ready  <= (wp_nxt - rp_nxt) != (PW+1)'(D);
            out_valid <= wp_nxt != rp_nxt;
            // head word: freshly pushed data bypasses when the fifo is empty after this cycle's pop
            if (push && wp_r[PW-1:0] == rp_nxt[PW-1:0])
                out_data <= in_data;
            else
                out_data <= mem_r[rp_nxt[PW-1:0]];
        end
    end

    // storage carries no reset; the head is only trusted while out_valid is high
    always_ff @(posedge sys_clk) begin
        if (ce && push)
            mem_r[wp_r[PW-1:0]] <= in_data;
    end
endmodule // mrc_fifo
`default_nettype wire

// file: tb/mrc_chk.sv
// Purpose: port checker for mrc_multirate
// Assumes: inputs change just after sys_clk rises
// Notes:   figures follow the slow period of four clocks
`timescale 1ns/1ps
`default_nettype none
module mrc_chk (
    input wire logic                    sys_clk,
    input wire logic                    nrst,
    input wire logic                    ce,
    input wire logic                    ce_clr,
    input wire logic [mrc_pkg::DW-1:0]  slow_in,
    input wire mrc_pkg::mrc_frame_t     par_in,
    input wire logic [mrc_pkg::AW-1:0]  store_addr,
    input wire logic                    ce_slow,
    input wire mrc_pkg::mrc_taps_t      taps,
    input wire mrc_pkg::mrc_frame_t     demux_out,
    input wire mrc_pkg::mrc_frame_t     par_out,
    input wire logic [mrc_pkg::DW-1:0]  ser_q_data,
    input wire logic                    ser_q_valid,
    input wire logic                    ser_q_ready
);
    import mrc_pkg::*;
    // a low ce freezes everything, so no timing relation is judged across it
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst || !ce);
    property p_clr_idle; ce_clr |=> !ce_slow; endproperty
    a_clr_idle: assert property (p_clr_idle) else $error("slow enable during clear");
    property p_first; $fell(ce_clr) ##1 !ce_clr [*2] |-> ##1 ce_slow; endproperty
    a_first: assert property (p_first) else $error("first pulse late");
    property p_gap; ce_slow |=> !ce_slow [*3]; endproperty
    a_gap: assert property (p_gap) else $error("slow enable too soon");
    property p_period; ce_slow ##1 !ce_clr [*4] |-> ce_slow; endproperty
    a_period: assert property (p_period) else $error("slow enable missed");
    property p_copy; 1'b1 |=> taps.up_copy == $past(slow_in); endproperty
    a_copy: assert property (p_copy) else $error("copy sampler wrong");
    property p_deser_freeze; ce_clr |=> $stable(par_out); endproperty
    a_deser_freeze: assert property (p_deser_freeze) else $error("frame moved in clear");
    property p_store_freeze;
        ce_clr ##1 (ce_clr && $stable(store_addr)) |=> $stable(taps.store_out);
    endproperty
    a_store_freeze: assert property (p_store_freeze) else $error("store moved");
    property p_last_hold; !$past(ce_slow) |-> $stable(taps.slow_last); endproperty
    a_last_hold: assert property (p_last_hold) else $error("last sample moved");
    property p_demux_hold; !$past(ce_slow) |-> $stable(demux_out); endproperty
    a_demux_hold: assert property (p_demux_hold) else $error("demux moved");
    property p_q_hold; ser_q_valid && !ser_q_ready |=> ser_q_valid && $stable(ser_q_data);
    endproperty
    a_q_hold: assert property (p_q_hold) else $error("queue head dropped");
    // the zero inserter must not fall back to zero right after a clear ends
    property p_zero_hold; $fell(ce_clr) |=> $stable(taps.up_zero); endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("zero insert moved");
    property p_mux_align; ce_slow |=> taps.mux_out == $past(par_in.ch0); endproperty
    a_mux_align: assert property (p_mux_align) else $error("mux not on frame start");
    property p_first_rate; $changed(taps.slow_first) |=> $stable(taps.slow_first); endproperty
    a_first_rate: assert property (p_first_rate) else $error("first sampler too fast");
endmodule // mrc_chk
bind mrc_multirate mrc_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .ce_clr(ce_clr),
    .slow_in(slow_in), .par_in(par_in), .store_addr(store_addr), .ce_slow(ce_slow), .taps(taps),
    .demux_out(demux_out), .par_out(par_out), .ser_q_data(ser_q_data),
    .ser_q_valid(ser_q_valid), .ser_q_ready(ser_q_ready));
`default_nettype wire

// file: tb/mrc_sys_model.sv
// Purpose: surrounding logic that clears the enables and pops the queue
// Assumes: bench pulses clr_len for one clock to request a clear
// Notes:   clear is high for two clocks out of reset, so no slow enable fires before release
`timescale 1ns/1ps
`default_nettype none
module mrc_sys_model (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic [3:0] clr_len,
    input  wire logic       stall,
    output logic            ce_clr,
    output logic            ser_q_ready
);
    logic [3:0] hold_r;
    logic [7:0] lfsr_r;
    // clear length counter and pseudo-random pop pattern
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hold_r <= 4'h2;
            lfsr_r <= 8'h5A;
        end else begin
            hold_r <= (clr_len != 4'h0) ? clr_len : hold_r - {3'h0, hold_r != 4'h0};
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        end
    end
    // the length counter alone drives the clear; no filter or counter reset is produced
    assign ce_clr      = (hold_r != 4'h0);
    assign ser_q_ready = !stall && lfsr_r[0];
endmodule // mrc_sys_model
`default_nettype wire

// file: tb/mrc_multirate_test.sv
// Purpose: random and corner tests of enable clearing
// Assumes: inputs change 1 ns after sys_clk rises
// Notes:   expectations follow a reference phase count
`timescale 1ns/1ps
`default_nettype none
module mrc_multirate_test;
    import mrc_pkg::*;
    logic                 sys_clk, nrst, ce, ce_clr, ce_slow, stall, rnd_ce;
    logic                 ser_q_valid, ser_q_ready, armed, ce_q, clr_q, rst_q;
    logic [DW-1:0]        fast_in, slow_in, ser_q_data, slow_q, fast_q;
    logic [AW-1:0]        store_addr;
    logic [3:0]           clr_len;
    mrc_frame_t           par_in, demux_out, par_out, par_q, pin_q;
    mrc_taps_t            taps;
    int                   n_fail, n_tests, seed, cnt;
    mrc_multirate u_dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .ce_clr(ce_clr),
        .fast_in(fast_in), .slow_in(slow_in), .par_in(par_in), .store_addr(store_addr),
        .ce_slow(ce_slow), .taps(taps), .demux_out(demux_out), .par_out(par_out),
        .ser_q_data(ser_q_data), .ser_q_valid(ser_q_valid), .ser_q_ready(ser_q_ready));
    mrc_sys_model u_sys (.sys_clk(sys_clk), .nrst(nrst), .clr_len(clr_len), .stall(stall),
        .ce_clr(ce_clr), .ser_q_ready(ser_q_ready));
    function automatic logic [DW-1:0] exp_word(input mrc_frame_t f, input int i);
        return f[DW*(i%4) +: DW];
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one clock of random data; the store index only moves while ce wanders
    task automatic step();
        @(posedge sys_clk);
        #1 ce = rnd_ce ? ($random(seed) % 8) != 0 : 1'b1;
        fast_in = DW'($random(seed));
        slow_in = DW'($random(seed));
        par_in = {$random(seed), $random(seed)};
        if (rnd_ce) store_addr = AW'($random(seed));
        stall = ($random(seed) % 4) == 0;
        clr_len = 4'h0;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // reference phase count, judged on values from before each edge
    always @(posedge sys_clk) begin
        if (nrst && rst_q && ce_q) begin
            // the model's enable of the previous edge decides what the samplers took
            if (armed && cnt == RATIO) begin
                check(64'(taps.slow_last), 64'(fast_q));
                check(64'(taps.up_zero), 64'(slow_q));
                check(64'(taps.ser_out), 64'(pin_q.ch0));
            end
            cnt = (clr_q || cnt == RATIO) ? 1 : cnt + 1;
            if (armed) check(64'(ce_slow), 64'(cnt == RATIO));
            check(64'(taps.up_copy), 64'(slow_q));
            if (clr_q) check(par_out, par_q);
            armed = armed | clr_q;
        end
        ce_q = ce;
        clr_q = ce_clr;
        rst_q = nrst;
        slow_q = slow_in;
        fast_q = fast_in;
        pin_q = par_in;
        par_q = par_out;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        stop_test();
    end
    initial begin
        seed = 64;
        n_fail = 0;
        n_tests = 0;
        cnt = 0;
        armed = 1'b0;
        rnd_ce = 1'b0;
        nrst = 1'b0;
        ce = 1'b1;
        fast_in = '0;
        slow_in = '0;
        store_addr = '0;
        clr_len = 4'h0;
        stall = 1'b1;
        par_in = {$random(seed), $random(seed)};
        repeat (10) @(posedge sys_clk);
        #1 nrst = 1'b1;
        // starve the queue until it refuses, then pop whole frames in order
        repeat (60) @(posedge sys_clk);
        check(64'(ser_q_valid), 64'h1);
        #1 stall = 1'b0;
        for (int i = 0; i < 16; ) begin
            @(posedge sys_clk);
            if (ser_q_valid === 1'b1 && ser_q_ready === 1'b1) begin
                check(64'(ser_q_data), 64'(exp_word(par_in, i)));
                i++;
            end
        end
        $display("test queue order done");
        rnd_ce = 1'b1;
        repeat (400) step();
        $display("test random ce done");
        // clears of 1, 2, 5 or 6 clocks at random points of the slow frame
        rnd_ce = 1'b0;
        repeat (15) begin
            step();
            clr_len = 4'(1 + ($random(seed) & 5));
            repeat (4 + ($random(seed) & 15)) step();
        end
        repeat (8) step();
        $display("test clear phases done");
        stop_test();
    end
endmodule // mrc_multirate_test
`default_nettype wire
